/* File: design/register_space_decode.sv */
`timescale 1ns/1ps
// Operation
// - LPC transaction carries exactly one data byte
// - Data port ignores low two address bits
// - No modulo-four address order expected
// - 64-byte write at 0x80 without incrementing
// - Partial register accesses decode correctly
// - Identifier register names supported interface
// - Long read returns start register first
// - Long write updates start register
// - Dropped bytes leave adjacent registers unchanged
// - Boundary crossing never aborts the transaction
// - Leftover data never reaches later transactions
// - Extended port takes one to maximum bytes
// - Starts at 0x81-0x83 alias the extended port
// - Longer bursts governed by burst count
// - Other registers decode to byte granularity
// - Multi-byte registers are little-endian
// - Buffer registers sit on aligned boundaries
// - Long buffer write touches only start register
// - Long buffer read returns only start register
// - Each locality owns a separate register range
module register_space_decode #(
    parameter int FIFO_DEPTH = 16,
    parameter bit BUFFER_SUPPORTED = 1'b0,
    // Identifier values are arbitrary
    parameter logic [31:0] QUEUE_ID_VALUE = 32'h0000_a501,
    parameter logic [31:0] BUFFER_ID_VALUE = 32'h0000_a502
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClock,
    input wire logic linkSelectN,
    input wire logic linkDataIn,
    input wire logic lpcMode,
    output logic linkDataOut,
    output logic linkDataOutEnable,
    output logic cmdValid,
    output logic [7:0] cmdData,
    input wire logic cmdReady,
    input wire logic respValid,
    input wire logic [7:0] respData,
    output logic respReady
);

    localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;
    localparam logic [31:0] IFID_WORD = BUFFER_SUPPORTED ? BUFFER_ID_VALUE : QUEUE_ID_VALUE;

    generate
        if (FIFO_DEPTH < 2 || FIFO_DEPTH >= (1 << regspace_pkg::BURST_W)) begin : g_bad_depth
            $error("FIFO_DEPTH does not fit the burst count field");
        end
    endgenerate

    typedef struct packed {
        regspace_pkg::link_pins_t stage1;
        regspace_pkg::link_pins_t stage2;
        regspace_pkg::link_pins_t stage3;
        regspace_pkg::link_pins_t pins;
        regspace_pkg::link_state_t phase;
        logic [2:0] bitCount;
        logic [1:0] headerCount;
        logic [7:0] rxShift;
        logic [7:0] txShift;
        logic isRead;
        logic lpcXfer;
        logic [6:0] remaining;
        logic [15:0] addr;
        regspace_pkg::reg_id_t startReg;
        logic [regspace_pkg::LOC_COUNT-1:0][31:0] ctrl;
        logic overflow;
        logic miso;
        logic misoOe;
        logic respReady;
    } state_t;

    state_t state;
    state_t next;

    regspace_pkg::link_pins_t agree;
    regspace_pkg::link_pins_t filt;
    logic rise;
    logic fall;
    logic byteDone;
    logic [7:0] rxByte;
    logic [15:0] targetAddr;
    regspace_pkg::reg_id_t curReg;
    logic startMatch;
    logic [2:0] curLoc;
    logic [1:0] curLane;
    logic [31:0] curCtrlWord;
    logic [31:0] laneMask;
    logic [31:0] statusWord;
    logic [31:0] readWord;
    logic [7:0] loadByte;
    logic readLoad;
    logic writeByte;
    logic ctrlWrite;
    logic ovfClear;
    logic pushValid;
    logic fifoInReady;
    logic [FILL_W-1:0] fifoCount;
    logic [regspace_pkg::BURST_W-1:0] burst_count_a;

    // Register decode inside a locality window, by word; the lane bits are masked off
    function automatic regspace_pkg::reg_id_t decodeReg(input logic [15:0] a);
        logic [11:0] word;
        word = a[11:0] & regspace_pkg::WORD_MASK;
        if (a[15] || a[regspace_pkg::LOC_LSB +: 3] >= 3'(regspace_pkg::LOC_COUNT)) begin
            return regspace_pkg::REG_NONE;
        end
        case (word)
            regspace_pkg::OFS_CTRL: return regspace_pkg::REG_CTRL;
            regspace_pkg::OFS_CAP: return regspace_pkg::REG_CAP;
            regspace_pkg::OFS_STATUS: return regspace_pkg::REG_STATUS;
            regspace_pkg::OFS_DATA: return regspace_pkg::REG_DATA;
            regspace_pkg::OFS_XDATA: return regspace_pkg::REG_XDATA;
            regspace_pkg::OFS_IFID: return regspace_pkg::REG_IFID;
            default: return regspace_pkg::REG_NONE;
        endcase
    endfunction : decodeReg

    function automatic logic isDataPort(input regspace_pkg::reg_id_t r);
        return (r == regspace_pkg::REG_DATA) || (r == regspace_pkg::REG_XDATA);
    endfunction : isDataPort

    // Data ports hold the address, everything else steps by one byte
    function automatic logic [15:0] advanceAddr(input logic [15:0] a,
                                                input regspace_pkg::reg_id_t r);
        return isDataPort(r) ? a : a + 16'h0001;
    endfunction : advanceAddr

    function automatic logic [7:0] laneByte(input logic [31:0] w, input logic [1:0] lane);
        return w[{lane, 3'b000} +: 8];
    endfunction : laneByte

    always_comb begin
        next = state;
        next.respReady = 1'b0;
        byteDone = 1'b0;
        readLoad = 1'b0;
        writeByte = 1'b0;
        ctrlWrite = 1'b0;
        ovfClear = 1'b0;
        pushValid = 1'b0;

        // Three-stage sampling; a bit moves once stages two and three agree
        next.stage1 = regspace_pkg::link_pins_t'({linkClock, linkSelectN, linkDataIn, lpcMode});
        next.stage2 = state.stage1;
        next.stage3 = state.stage2;
        agree = regspace_pkg::link_pins_t'(~(state.stage2 ^ state.stage3));
        filt = regspace_pkg::link_pins_t'((state.pins & ~agree) | (state.stage2 & agree));
        next.pins = filt;
        rise = filt.sclk & ~state.pins.sclk;
        fall = ~filt.sclk & state.pins.sclk;
        rxByte = {state.rxShift[6:0], filt.mosi};

        if (state.phase == regspace_pkg::LINK_HEADER) begin
            targetAddr = {state.addr[15:8], rxByte};
        end else begin
            targetAddr = state.addr;
        end
        curReg = decodeReg(targetAddr);
        curLoc = targetAddr[regspace_pkg::LOC_LSB +: 3];
        curLane = targetAddr[1:0];
        startMatch = (state.phase == regspace_pkg::LINK_HEADER) || (curReg == state.startReg);
        laneMask = 32'h0000_00ff << {curLane, 3'b000};
        if (curLoc < 3'(regspace_pkg::LOC_COUNT)) begin
            curCtrlWord = state.ctrl[curLoc];
        end else begin
            curCtrlWord = 32'h0000_0000;
        end

        burst_count_a = regspace_pkg::BURST_W'(FIFO_DEPTH) - regspace_pkg::BURST_W'(fifoCount);
        statusWord = 32'h0000_0000;
        statusWord[regspace_pkg::STS_BURST_LSB +: regspace_pkg::BURST_W] = burst_count_a;
        statusWord[regspace_pkg::STS_AVAIL_BIT] = respValid;
        statusWord[regspace_pkg::STS_OVERFLOW_BIT] = state.overflow;

        case (curReg)
            regspace_pkg::REG_CTRL: readWord = curCtrlWord;
            regspace_pkg::REG_CAP: readWord = 32'(regspace_pkg::MAX_XFER);
            regspace_pkg::REG_STATUS: readWord = statusWord;
            regspace_pkg::REG_IFID: readWord = IFID_WORD;
            default: readWord = 32'h0000_0000;
        endcase
        // Bytes past the start register read as dummy data
        if (!startMatch) begin
            loadByte = regspace_pkg::DUMMY_BYTE;
        end else if (isDataPort(curReg)) begin
            loadByte = respValid ? respData : regspace_pkg::DUMMY_BYTE;
        end else begin
            loadByte = laneByte(readWord, curLane);
        end

        if (filt.csN) begin
            next.phase = regspace_pkg::LINK_IDLE;
            next.bitCount = 3'h0;
            next.headerCount = 2'h0;
            next.txShift = 8'h00;
            next.remaining = 7'h00;
            next.miso = 1'b0;
            next.misoOe = 1'b0;
        end else begin
            next.misoOe = 1'b1;
            if (state.phase == regspace_pkg::LINK_IDLE) begin
                next.phase = regspace_pkg::LINK_HEADER;
                next.lpcXfer = filt.lpcMode;
            end else begin
                if (fall) begin
                    next.miso = state.txShift[7];
                    next.txShift = {state.txShift[6:0], 1'b0};
                end
                if (rise) begin
                    next.rxShift = rxByte;
                    next.bitCount = state.bitCount + 3'h1;
                    byteDone = (state.bitCount == 3'h7);
                end
            end
        end

        if (byteDone) begin
            case (state.phase)
                regspace_pkg::LINK_HEADER: begin
                    next.headerCount = state.headerCount + 2'h1;
                    case (state.headerCount)
                        2'h0: begin
                            next.isRead = rxByte[regspace_pkg::CMD_READ_BIT];
                            if (state.lpcXfer) begin
                                next.remaining = 7'h01;
                            end else begin
                                next.remaining = {1'b0, rxByte[regspace_pkg::CMD_LEN_MSB:0]}
                                                 + 7'h01;
                            end
                        end
                        2'h1: begin
                            next.addr[15:8] = rxByte;
                        end
                        default: begin
                            next.addr = targetAddr;
                            next.startReg = curReg;
                            next.phase = regspace_pkg::LINK_DATA;
                            readLoad = state.isRead;
                        end
                    endcase
                end
                regspace_pkg::LINK_DATA: begin
                    if (state.remaining != 7'h00) begin
                        next.remaining = state.remaining - 7'h01;
                        writeByte = !state.isRead;
                        readLoad = state.isRead && (state.remaining > 7'h01);
                    end
                end
                default: ;
            endcase
        end

        if (readLoad) begin
            next.txShift = loadByte;
            next.addr = advanceAddr(targetAddr, curReg);
            if (startMatch && isDataPort(curReg) && respValid) begin
                next.respReady = 1'b1;
            end
        end

        // Writes outside the start register are dropped whole
        if (writeByte) begin
            next.addr = advanceAddr(targetAddr, curReg);
            if (startMatch) begin
                case (curReg)
                    regspace_pkg::REG_CTRL: begin
                        next.ctrl[curLoc][{curLane, 3'b000} +: 8] = rxByte;
                        ctrlWrite = 1'b1;
                    end
                    regspace_pkg::REG_STATUS: begin
                        ovfClear = (curLane == 2'h0) && rxByte[regspace_pkg::STS_OVERFLOW_BIT];
                    end
                    regspace_pkg::REG_DATA, regspace_pkg::REG_XDATA: begin
                        pushValid = curCtrlWord[regspace_pkg::CTRL_DATA_EN_BIT];
                    end
                    default: ;
                endcase
            end
        end

        // A lost byte in the same cycle as a clear keeps the flag set
        next.overflow = (state.overflow & ~ovfClear) | (pushValid & ~fifoInReady);

        if (rst) begin
            next = '0;
            next.stage1.csN = 1'b1;
            next.stage2.csN = 1'b1;
            next.stage3.csN = 1'b1;
            next.pins.csN = 1'b1;
            for (int i = 0; i < regspace_pkg::LOC_COUNT; i++) begin
                next.ctrl[i] = regspace_pkg::CTRL_RESET;
            end
            pushValid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state <= next;
    end

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(pushValid),
        .inData(rxByte),
        .inReady(fifoInReady),
        .outValid(cmdValid),
        .outData(cmdData),
        .outReady(cmdReady),
        .fillCount(fifoCount)
    );

    assign linkDataOut = state.miso;
    assign linkDataOutEnable = state.misoOe;
    assign respReady = state.respReady;

    sequence respPulse;
        state.respReady ##1 !state.respReady;
    endsequence
    sequence quietLink;
        (state.phase == regspace_pkg::LINK_IDLE) && (state.txShift == 8'h00) && !state.misoOe;
    endsequence

    AST_LEFTOVER_CLEARED: assert property (@(posedge clk) disable iff (rst)
        (filt.csN && !state.pins.csN) |=> quietLink)
        else $error("transfer state survived deselect");
    AST_LPC_SINGLE_BYTE: assert property (@(posedge clk) disable iff (rst)
        (byteDone && state.phase == regspace_pkg::LINK_HEADER && state.headerCount == 2'h0
         && state.lpcXfer) |=> (state.remaining == 7'h01))
        else $error("LPC transfer allowed more than one data byte");
    AST_DATA_PORT_HOLDS_ADDR: assert property (@(posedge clk) disable iff (rst)
        ((writeByte || readLoad) && isDataPort(curReg) && state.phase == regspace_pkg::LINK_DATA)
        |=> $stable(state.addr))
        else $error("data port address advanced");
    AST_DROPPED_WRITE_STABLE: assert property (@(posedge clk) disable iff (rst)
        (writeByte && !startMatch) |=> ($stable(state.ctrl) && !$rose(state.overflow)))
        else $error("dropped byte changed a register");
    AST_LANE_ONLY: assert property (@(posedge clk) disable iff (rst)
        ctrlWrite |=> (((state.ctrl[$past(curLoc)] ^ $past(curCtrlWord)) & ~$past(laneMask))
                       == 32'h0000_0000))
        else $error("partial write touched other byte lanes");
    AST_OVERFLOW_SET_WINS: assert property (@(posedge clk) disable iff (rst)
        (pushValid && !fifoInReady) |=> state.overflow)
        else $error("lost byte did not raise overflow");
    AST_POP_ONE_PULSE: assert property (@(posedge clk) disable iff (rst)
        (readLoad && startMatch && isDataPort(curReg) && respValid) |=> respPulse)
        else $error("response pop is not a single pulse");
    AST_IDENTIFIER_BYTE: assert property (@(posedge clk) disable iff (rst)
        (readLoad && startMatch && curReg == regspace_pkg::REG_IFID && curLane == 2'h0)
        |=> (state.txShift == IFID_WORD[7:0]))
        else $error("identifier read returned wrong byte");
    AST_WORD_LITTLE_ENDIAN: assert property (@(posedge clk) disable iff (rst)
        (readLoad && startMatch && curReg == regspace_pkg::REG_CAP && curLane == 2'h0)
        |=> (state.txShift == 8'(regspace_pkg::MAX_XFER)))
        else $error("lowest address did not return bits 7:0");

endmodule : register_space_decode

/* File: design/regspace_pkg.sv */
package regspace_pkg;

    // Locality windows
    localparam int LOC_LSB = 12;
    localparam int LOC_COUNT = 5;

    // Register word offsets inside one locality window
    localparam logic [11:0] OFS_CTRL = 12'h008;
    localparam logic [11:0] OFS_CAP = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_DATA = 12'h024;
    localparam logic [11:0] OFS_IFID = 12'h030;
    localparam logic [11:0] OFS_XDATA = 12'h080;
    localparam logic [11:0] WORD_MASK = 12'hffc;

    // Link framing: command byte, address high, address low, then data
    localparam int HEADER_BYTES = 3;
    localparam int CMD_READ_BIT = 7;
    localparam int CMD_LEN_MSB = 5;
    localparam int MAX_XFER = 64;

    // Field layouts and reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_DATA_EN_BIT = 0;
    localparam int STS_OVERFLOW_BIT = 3;
    localparam int STS_AVAIL_BIT = 4;
    localparam int STS_BURST_LSB = 8;
    localparam int BURST_W = 16;
    localparam logic [7:0] DUMMY_BYTE = 8'hff;

    // Input synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_CTRL,
        REG_CAP,
        REG_STATUS,
        REG_DATA,
        REG_XDATA,
        REG_IFID
    } reg_id_t;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_HEADER,
        LINK_DATA
    } link_state_t;

    typedef struct packed {
        logic sclk;
        logic csN;
        logic mosi;
        logic lpcMode;
    } link_pins_t;

endpackage : regspace_pkg

/* File: design/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    output logic [$clog2(DEPTH):0] fillCount
);

    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
            $error("byte_fifo needs a power-of-two depth of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic outValid;
        logic [WIDTH-1:0] outData;
    } fifo_state_t;

    fifo_state_t state;
    fifo_state_t next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign inReady = (state.count != (AW + 1)'(DEPTH));
    assign push = inValid && inReady;
    assign pop = state.outValid && outReady;
    assign outValid = state.outValid;
    assign outData = state.outData;
    assign fillCount = state.count;

    always_comb begin
        next = state;
        next.count = state.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next.rd = state.rd + {{(AW - 1){1'b0}}, pop};
        if (push) begin
            next.wr = state.wr + {{(AW - 1){1'b0}}, 1'b1};
        end
        next.outValid = (next.count != '0);
        // Head word comes from the write port when it lands in an empty queue
        if ((state.count - {{AW{1'b0}}, pop}) == '0) begin
            next.outData = inData;
        end else begin
            next.outData = mem[next.rd];
        end
        if (rst) begin
            next = '0;
        end
    end

    always_ff @(posedge clk) begin
        state <= next;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[state.wr] <= inData;
        end
    end

endmodule : byte_fifo

/* File: dv/link_host.sv */
`timescale 1ns/1ps
module link_host (
    output logic linkClock,
    output logic linkSelectN,
    output logic linkDataIn,
    input wire logic linkDataOut,
    input wire logic linkDataOutEnable
);
    logic [7:0] txBytes [0:66];
    logic [7:0] rxBytes [0:66];

    initial begin
        linkClock = 1'b0;
        linkSelectN = 1'b1;
        linkDataIn = 1'b0;
    end

    // Clock idles low; data moves while low, read back just before the fall
    task automatic frame(input int nBytes, input int cutBits);
        int nBits;
        nBits = (cutBits > 0) ? cutBits : nBytes * 8;
        #13 linkSelectN = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            // Bytes leave lowest address first, MSB first within a byte
            #13 linkDataIn = txBytes[i / 8][7 - i % 8];
            #87 linkClock = 1'b1;
            #99 rxBytes[i / 8][7 - i % 8] = linkDataOutEnable ? linkDataOut : 1'bx;
            #1 linkClock = 1'b0;
        end
        #100 linkSelectN = 1'b1;
        // Released line must not keep showing the last bit
        linkDataIn = ~linkDataIn;
        #300;
    endtask : frame
endmodule : link_host

/* File: dv/tb_register_space_decode.sv */
`timescale 1ns/1ps
module tb_register_space_decode;
    localparam logic [31:0] QID = 32'h00c3_a501;
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
        logic [7:0] len;
        logic [63:0] val;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{1'b1, 16'h0030, 8'h04, {32'h0, QID}},
        '{1'b1, 16'h0032, 8'h01, 64'hc3},
        '{1'b1, 16'h0030, 8'h08, {32'hffff_ffff, QID}},
        '{1'b1, 16'h0014, 8'h04, 64'h40},
        '{1'b0, 16'h1008, 8'h08, {32'h5a5a_5a5a, 32'h0}},
        '{1'b1, 16'h1008, 8'h04, 64'h0},
        '{1'b1, 16'h100c, 8'h04, 64'h0},
        '{1'b1, 16'h0008, 8'h04, 64'h1}
    };
    localparam logic [7:0] LPCA [4] = '{8'h24, 8'h25, 8'h27, 8'h26};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lpcMode = 1'b0;
    logic cmdReady = 1'b1;
    logic respValid = 1'b0;
    logic [7:0] respData = 8'h00;
    logic linkClock, linkSelectN, linkDataIn, linkDataOut, linkDataOutEnable;
    logic cmdValid, respReady;
    logic [7:0] cmdData;
    logic [7:0] got[$];
    logic [7:0] respQ[$];
    logic [63:0] rdVal;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #12.5 clk = ~clk;

    register_space_decode #(.FIFO_DEPTH(16), .QUEUE_ID_VALUE(QID)) register_space_decode_inst (
        .clk(clk), .rst(rst), .linkClock(linkClock), .linkSelectN(linkSelectN),
        .linkDataIn(linkDataIn), .lpcMode(lpcMode), .linkDataOut(linkDataOut),
        .linkDataOutEnable(linkDataOutEnable), .cmdValid(cmdValid), .cmdData(cmdData),
        .cmdReady(cmdReady), .respValid(respValid), .respData(respData), .respReady(respReady)
    );
    link_host link_host_inst (
        .linkClock(linkClock), .linkSelectN(linkSelectN), .linkDataIn(linkDataIn),
        .linkDataOut(linkDataOut), .linkDataOutEnable(linkDataOutEnable)
    );

    // Sink collects popped bytes; source serves queued response bytes
    always @(posedge clk) begin
        if (cmdValid === 1'b1 && cmdReady) got.push_back(cmdData);
        if (respReady === 1'b1 && respQ.size() > 0) void'(respQ.pop_front());
        respValid <= respQ.size() > 0;
        respData <= (respQ.size() > 0) ? respQ[0] : 8'h00;
    end

    task automatic check(input logic [63:0] act, input logic [63:0] exp);
        cmp_count++;
        if (act !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check

    task automatic xfer(input logic rd, input logic [15:0] addr, input int len, input int cut);
        link_host_inst.txBytes[0] = {rd, 1'b0, 6'(len - 1)};
        link_host_inst.txBytes[1] = addr[15:8];
        link_host_inst.txBytes[2] = addr[7:0];
        link_host_inst.frame(len + 3, cut);
        rdVal = '0;
        for (int i = 0; i < 8 && i < len; i++) rdVal[i*8 +: 8] = link_host_inst.rxBytes[i + 3];
    endtask : xfer

    task automatic access(input row_t r);
        for (int i = 0; i < 8; i++) link_host_inst.txBytes[i + 3] = r.val[i*8 +: 8];
        xfer(r.rd, r.addr, int'(r.len), 0);
        if (r.rd) check(rdVal, r.val);
    endtask : access

    task automatic drain(input int n);
        @(posedge clk);
        cmdReady <= 1'b1;
        for (int i = 0; i < 400 && got.size() < n; i++) @(posedge clk);
        check(64'(got.size()), 64'(n));
    endtask : drain

    task automatic tend(input string name);
        $display("test %s finished", name);
    endtask : tend

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    initial begin
        #2_000_000;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(64'({cmdValid, cmdData, respReady, linkDataOutEnable, linkDataOut}), 64'h0);
        tend("reset");
        foreach (ROWS[i]) access(ROWS[i]);
        tend("table");
        // Single-byte link mode, out-of-order data port addresses, length field ignored
        @(posedge clk);
        lpcMode <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            link_host_inst.txBytes[3] = 8'h55 + 8'(k * 17);
            link_host_inst.txBytes[4] = 8'hee;
            xfer(1'b0, {8'h00, LPCA[k]}, 2, 0);
        end
        @(posedge clk);
        lpcMode <= 1'b0;
        access('{1'b0, 16'h0024, 8'h04, 64'h4433_2211});
        access('{1'b0, 16'h0082, 8'h02, 64'haa99});
        drain(10);
        foreach (got[i]) check(64'(got[i]), 64'({8'h55, 8'h66, 8'h77, 8'h88, 8'h11, 8'h22,
            8'h33, 8'h44, 8'h99, 8'haa} >> (8 * (9 - i))) & 64'hff);
        tend("data port");
        // Full burst to the extended port while the sink stalls
        @(posedge clk);
        cmdReady <= 1'b0;
        got.delete();
        for (int i = 0; i < 64; i++) link_host_inst.txBytes[i + 3] = 8'(i);
        xfer(1'b0, 16'h0080, 64, 0);
        access('{1'b1, 16'h0018, 8'h04, 64'h0000_0008});
        access('{1'b0, 16'h0018, 8'h01, 64'h08});
        drain(16);
        foreach (got[i]) check(64'(got[i]), 64'(i));
        access('{1'b1, 16'h0018, 8'h04, 64'h0000_1000});
        tend("overflow");
        respQ = '{8'ha1, 8'hb2};
        access('{1'b1, 16'h0024, 8'h03, 64'hffb2a1});
        tend("response");
        // Frame cut after four data bits must leave nothing behind
        for (int i = 0; i < 4; i++) link_host_inst.txBytes[i + 3] = 8'h00;
        xfer(1'b0, 16'h0008, 4, 28);
        access('{1'b1, 16'h0008, 8'h04, 64'h1});
        access('{1'b1, 16'h0030, 8'h04, {32'h0, QID}});
        tend("abort");
        access('{1'b0, 16'h0008, 8'h04, 64'h0});
        // Data port writes are dropped while the enable bit is clear
        got.delete();
        access('{1'b0, 16'h0024, 8'h01, 64'h77});
        check(64'(got.size()), 64'h0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        access('{1'b1, 16'h0008, 8'h04, 64'h1});
        tend("second reset");
        results();
    end
endmodule : tb_register_space_decode
